/* core/arcdr_top.sv */
// Purpose: Register-controlled clock and data routing for audio ports
//          one and two, plus the gain-ramp frame clock selector.
// Assumes: Single AHB-Lite master; word transfers only.
// Notes:   Routed pins are combinational pass-through of their source.
// Contract
// - Without force a clock-source change waits until old and new clocks are both low, with force it happens at once.
// - Ramp codes 0-4 pick port frame clocks 1-5, 5 and 6 the playback frame clocks, 7 the record frame clock.
// - The ramp source changes only on a write with its apply bit set.
// - Port one master clock code 0 is input, 1-4 drive ports 2-5, 5-7 are reserved.
// - A data pin is input at its own port code, otherwise driven from a port, GPIO, or code 7 record data.
// - Port fields are only stored unless the apply bit is written, which applies them all together.
`timescale 1ns/1ns
`default_nettype none
`include "arcdr_regs.svh"
module arcdr_top
  import arcdr_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [4:0] master_clk_in,
  input wire logic [4:0] bit_clk_in,
  input wire logic [4:0] frame_clk_in,
  input wire logic [4:0] data_in,
  input wire logic [1:0] gpio_data_in,
  input wire logic playback_one_bit_clock_in,
  input wire logic playback_one_frame_clock_in,
  input wire logic playback_two_bit_clock_in,
  input wire logic playback_two_frame_clock_in,
  input wire logic record_bit_clock_in,
  input wire logic record_frame_clock_in,
  input wire logic record_data_in,
  output logic [1:0] master_clk_out,
  output logic [1:0] master_clk_oe_out,
  output logic [1:0] bit_clk_out,
  output logic [1:0] frame_clk_out,
  output logic [1:0] pair_oe_out,
  output logic [1:0] data_out,
  output logic [1:0] data_oe_out,
  output logic ramp_clock_out
);
  arcdr_bus_t state_r;
  arcdr_bus_t state_nxt;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic addr_ok_r;
  logic addr_ok_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [15:0] ramp_reg_r;
  logic [15:0] ramp_reg_nxt;
  logic [15:0] port_reg_r [2];
  logic [15:0] port_reg_nxt [2];
  logic accept;
  logic wr_now;
  logic ramp_req;
  logic [1:0] port_req;
  logic [20:0] sync_out;
  logic [7:0] master_s8;
  logic [7:0] bit_s8;
  logic [7:0] frame_s8;
  logic [7:0] master_raw8;
  logic [7:0] bit_raw8;
  logic [7:0] frame_raw8;
  logic [7:0] data_raw8;
  logic [2:0] ramp_hold;
  logic [2:0] ramp_act;
  logic ramp_pend;
  logic ramp_safe;
  arcdr_route_t port_hold [2];
  arcdr_route_t port_act [2];
  logic [1:0] port_pend;
  logic [1:0] port_safe;

  // Address phase taken on a ready cycle with a NONSEQ/SEQ transfer
  assign accept = hsel_in && hready_in && htrans_in[1];
  assign wr_now = (state_r == BUS_WRITE) && clk_en_in;

  // Bus phase tracking, register writes and read data
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    addr_ok_nxt = addr_ok_r;
    rdata_nxt = rdata_r;
    ramp_reg_nxt = ramp_reg_r;
    port_reg_nxt = port_reg_r;
    ramp_req = 1'b0;
    port_req = 2'b00;
    if (clk_en_in) begin
      if (state_r == BUS_READ) begin
        state_nxt = BUS_RDOUT;
        rdata_nxt = 32'h00000000;
        if (addr_ok_r) begin
          case (idx_r)
            `ARCDR_RAMP_IDX: rdata_nxt[15:0] = ramp_reg_r;
            `ARCDR_PORT1_IDX: rdata_nxt[15:0] = port_reg_r[0];
            `ARCDR_PORT2_IDX: rdata_nxt[15:0] = port_reg_r[1];
            `ARCDR_STATUS_IDX: rdata_nxt[15:0] = {9'h000, ramp_act,
              1'b0, port_pend, ramp_pend};
            default: rdata_nxt = 32'h00000000;
          endcase
        end
      end else if (accept) begin
        state_nxt = hwrite_in ? BUS_WRITE : BUS_READ;
        idx_nxt = haddr_in[9:2];
        addr_ok_nxt = (haddr_in[31:10] == 22'h000000);
      end else begin
        state_nxt = BUS_IDLE;
      end
      if (state_r == BUS_WRITE && addr_ok_r) begin
        case (idx_r)
          `ARCDR_RAMP_IDX: begin
            ramp_reg_nxt = hwdata_in[15:0] & `ARCDR_RAMP_MASK;
            ramp_req = hwdata_in[`ARCDR_APPLY_BIT];
          end
          `ARCDR_PORT1_IDX: begin
            port_reg_nxt[0] = hwdata_in[15:0] & `ARCDR_PORT_MASK;
            port_req[0] = hwdata_in[`ARCDR_APPLY_BIT];
          end
          `ARCDR_PORT2_IDX: begin
            port_reg_nxt[1] = hwdata_in[15:0] & `ARCDR_PORT_MASK;
            port_req[1] = hwdata_in[`ARCDR_APPLY_BIT];
          end
          default: ramp_reg_nxt = ramp_reg_r;
        endcase
      end
    end
  end

  // Bus and register state
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= BUS_IDLE;
      idx_r <= 8'h00;
      addr_ok_r <= 1'b0;
      rdata_r <= 32'h00000000;
      ramp_reg_r <= `ARCDR_RAMP_RST;
      port_reg_r[0] <= `ARCDR_PORT1_RST;
      port_reg_r[1] <= `ARCDR_PORT2_RST;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      addr_ok_r <= addr_ok_nxt;
      rdata_r <= rdata_nxt;
      ramp_reg_r <= ramp_reg_nxt;
      port_reg_r <= port_reg_nxt;
    end
  end

  // One wait state on reads so a preceding write is always visible
  assign hreadyout_out = (state_r != BUS_READ);
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_r;

  // Pin clocks are sampled only for the safe-switch decision
  arcdr_sync #(.W(21)) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .level_in({record_frame_clock_in, playback_two_frame_clock_in,
      playback_one_frame_clock_in, record_bit_clock_in,
      playback_two_bit_clock_in, playback_one_bit_clock_in,
      frame_clk_in, bit_clk_in, master_clk_in}),
    .level_out(sync_out)
  );

  // Eight-entry source tables: ports 1-5 then converters, GPIO, or zero for the master clock tables
  assign master_s8 = {3'b000, sync_out[4:0]};
  assign bit_s8 = {sync_out[17:15], sync_out[9:5]};
  assign frame_s8 = {sync_out[20:18], sync_out[14:10]};
  assign master_raw8 = {3'b000, master_clk_in};
  assign bit_raw8 = {record_bit_clock_in, playback_two_bit_clock_in,
    playback_one_bit_clock_in, bit_clk_in};
  assign frame_raw8 = {record_frame_clock_in, playback_two_frame_clock_in,
    playback_one_frame_clock_in, frame_clk_in};
  assign data_raw8 = {record_data_in, gpio_data_in, data_in};

  // Ramp clock: both the old and the new frame clock must be low
  assign ramp_safe = !frame_s8[ramp_hold] && !frame_s8[ramp_act];

  arcdr_apply_gate #(.W(3), .RST_VAL(3'(`ARCDR_RAMP_RST >> 1))) u_ramp_gate (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .req_in(ramp_req),
    .force_in(hwdata_in[`ARCDR_FORCE_BIT]),
    .safe_in(ramp_safe),
    .value_in(hwdata_in[`ARCDR_SEL_LSB +: 3]),
    .hold_out(ramp_hold),
    .active_out(ramp_act),
    .pending_out(ramp_pend)
  );

  // Selected frame clock goes straight out
  assign ramp_clock_out = frame_raw8[ramp_act];

  // Per-port routing; a code equal to the port's index p (port one 0, port two 1) is input
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [2:0] m_act;
    logic [2:0] q_act;
    logic [2:0] d_act;
    logic [2:0] m_hold;
    logic [2:0] q_hold;
    logic m_drive;
    logic q_drive;
    logic d_drive;
    logic lvl_old;
    logic lvl_new;

    assign m_act = port_act[p][2:0];
    assign q_act = port_act[p][5:3];
    assign d_act = port_act[p][8:6];
    assign m_hold = port_hold[p][2:0];
    assign q_hold = port_hold[p][5:3];

    // Master clock: reserved codes 5-7 leave the pin undriven
    assign m_drive = (m_act != 3'(p)) && (m_act < 3'h5);
    assign q_drive = (q_act != 3'(p));
    assign d_drive = (d_act != 3'(p));

    // Source levels seen by the switch decision, input reads as low
    assign lvl_old = ((m_act != 3'(p)) && master_s8[m_act])
      || ((q_act != 3'(p)) && (bit_s8[q_act] || frame_s8[q_act]));
    assign lvl_new = ((m_hold != 3'(p)) && master_s8[m_hold])
      || ((q_hold != 3'(p)) && (bit_s8[q_hold] || frame_s8[q_hold]));
    assign port_safe[p] = !lvl_old && !lvl_new;

    // Active value is the register image without its force bit
    arcdr_apply_gate #(
      .W(9),
      .RST_VAL(9'((p == 0 ? `ARCDR_PORT1_RST : `ARCDR_PORT2_RST) >> 1))
    ) u_gate (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .req_in(port_req[p]),
      .force_in(hwdata_in[`ARCDR_FORCE_BIT]),
      .safe_in(port_safe[p]),
      .value_in(hwdata_in[`ARCDR_SEL_LSB +: 9]),
      .hold_out(port_hold[p]),
      .active_out(port_act[p]),
      .pending_out(port_pend[p])
    );

    // Pins follow their source combinationally; input means no drive
    assign master_clk_out[p] = m_drive & master_raw8[m_act];
    assign master_clk_oe_out[p] = m_drive;
    assign bit_clk_out[p] = q_drive & bit_raw8[q_act];
    assign frame_clk_out[p] = q_drive & frame_raw8[q_act];
    assign pair_oe_out[p] = q_drive;
    assign data_out[p] = d_drive & data_raw8[d_act];
    assign data_oe_out[p] = d_drive;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  // Ramp code 5 carries the first playback frame clock
  ramp_pick_a: assert property (ramp_act == 3'h5
    |-> ramp_clock_out == playback_one_frame_clock_in)
    else $error("ramp code 5 not routed");

  // A ramp write without apply starts no switch
  sequence ramp_plain_wr;
    wr_now && addr_ok_r && idx_r == `ARCDR_RAMP_IDX
      && !hwdata_in[`ARCDR_APPLY_BIT];
  endsequence
  ramp_hold_a: assert property (ramp_plain_wr and !ramp_pend
    |=> $stable(ramp_act) && !ramp_pend)
    else $error("ramp source moved without apply");

  // Port one master clock: input and reserved codes never drive
  mclk_input_a: assert property (port_act[0][2:0] == 3'h0
    || port_act[0][2:0] > 3'h4 |-> !master_clk_oe_out[0])
    else $error("port one master clock driven");

  // Port two pair code 0 repeats port one's clocks
  pair_repeat_a: assert property (port_act[1][5:3] == 3'h0
    |-> pair_oe_out[1] && bit_clk_out[1] == bit_clk_in[0]
      && frame_clk_out[1] == frame_clk_in[0])
    else $error("port two pair not from port one");

  // Data code 7 carries record converter data
  data_rec_a: assert property (port_act[0][8:6] == 3'h7
    |-> data_oe_out[0] && data_out[0] == record_data_in)
    else $error("record data not routed");

  // Port write without apply: stored now, active settings untouched
  sequence port_plain_wr;
    wr_now && addr_ok_r && idx_r == `ARCDR_PORT2_IDX
      && !hwdata_in[`ARCDR_APPLY_BIT] && !port_pend[1];
  endsequence
  port_store_a: assert property (port_plain_wr
    |=> port_reg_r[1] == ($past(hwdata_in[15:0]) & `ARCDR_PORT_MASK)
      && $stable(port_act[1])
      ##1 ($stable(port_act[1]) || $past(port_req[1])))
    else $error("port settings applied without apply");

  // Own code on a data pin means the pin is released
  data_release_a: assert property (port_act[1][8:6] == 3'h1
    |-> !data_oe_out[1] && !data_out[1])
    else $error("input data pin driven");
endmodule : arcdr_top
`default_nettype wire

/* common/arcdr_regs.svh */
// Purpose: Offsets, field positions and reset values of the audio port
//          clock and data router.
// Assumes: Included by bare name; definitions only.
// Notes:   Byte address of a register is four times its index.
`ifndef ARCDR_REGS_SVH
`define ARCDR_REGS_SVH

// Register indices (byte address = index * 4)
`define ARCDR_RAMP_IDX 8'h24
`define ARCDR_PORT1_IDX 8'h25
`define ARCDR_PORT2_IDX 8'h26
`define ARCDR_STATUS_IDX 8'h30

// Field positions of the control registers; pair and data fields are in the two port registers only
`define ARCDR_FORCE_BIT 0
`define ARCDR_SEL_LSB 1
`define ARCDR_PAIR_LSB 4
`define ARCDR_DATA_LSB 7
`define ARCDR_APPLY_BIT 10

// Stored-bit masks (apply bit reads back as zero)
`define ARCDR_RAMP_MASK 16'h000F
`define ARCDR_PORT_MASK 16'h03FF

// Reset values
`define ARCDR_RAMP_RST 16'h0002
`define ARCDR_PORT1_RST 16'h0000
`define ARCDR_PORT2_RST 16'h0092

`endif

/* common/arcdr_pkg.sv */
// Purpose: Types of the audio port clock and data router.
// Assumes: Compiled before all core files.
// Notes:   Bus phase states are one-hot.
`default_nettype none
package arcdr_pkg;

  // Bus slave phase
  typedef enum logic [3:0] {
    BUS_IDLE  = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ  = 4'b0100,
    BUS_RDOUT = 4'b1000
  } arcdr_bus_t;

  // Active routing of one port: data, pair, master clock codes
  typedef logic [8:0] arcdr_route_t;

endpackage : arcdr_pkg
`default_nettype wire

/* core/arcdr_sync.sv */
// Purpose: Two-stage synchroniser for a vector of independent levels.
// Assumes: Bits are unrelated; no word coherence is promised.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module arcdr_sync #(
  parameter int W = 21
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [W-1:0] level_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] stab_r;
  logic [W-1:0] stab_nxt;

  // Refuse widths the logic cannot serve
  if (W < 1) begin : g_bad_w
    $error("arcdr_sync: W must be at least 1");
  end

  // Next values, held while the clock enable is low
  always_comb begin
    meta_nxt = clk_en_in ? level_in : meta_r;
    stab_nxt = clk_en_in ? meta_r : stab_r;
  end

  // Two flip-flop stages
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      stab_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      stab_r <= stab_nxt;
    end
  end

  assign level_out = stab_r;
endmodule : arcdr_sync
`default_nettype wire

/* core/arcdr_apply_gate.sv */
// Purpose: Holds a requested selector value and moves it to the active
//          value either at once (forced) or when the clocks are safe.
// Assumes: safe_in is computed from hold_out and active_out by the owner.
// Notes:   A new request in the cycle of a deferred apply wins.
`timescale 1ns/1ns
`default_nettype none
module arcdr_apply_gate #(
  parameter int W = 9,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic req_in,
  input wire logic force_in,
  input wire logic safe_in,
  input wire logic [W-1:0] value_in,
  output logic [W-1:0] hold_out,
  output logic [W-1:0] active_out,
  output logic pending_out
);
  logic pend_r;
  logic pend_nxt;
  logic force_r;
  logic force_nxt;
  logic [W-1:0] hold_r;
  logic [W-1:0] hold_nxt;
  logic [W-1:0] active_r;
  logic [W-1:0] active_nxt;

  // Refuse widths the logic cannot serve
  if (W < 1) begin : g_bad_w
    $error("arcdr_apply_gate: W must be at least 1");
  end

  // Deferred apply, then a fresh request on top of it
  always_comb begin
    pend_nxt = pend_r;
    force_nxt = force_r;
    hold_nxt = hold_r;
    active_nxt = active_r;
    if (pend_r && (force_r || safe_in)) begin
      active_nxt = hold_r;
      pend_nxt = 1'b0;
    end
    if (req_in) begin
      hold_nxt = value_in;
      force_nxt = force_in;
      pend_nxt = ~force_in;
      if (force_in) begin
        active_nxt = value_in;
      end
    end
    if (!clk_en_in) begin
      pend_nxt = pend_r;
      force_nxt = force_r;
      hold_nxt = hold_r;
      active_nxt = active_r;
    end
  end

  // State registers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_r <= 1'b0;
      force_r <= 1'b0;
      hold_r <= RST_VAL;
      active_r <= RST_VAL;
    end else begin
      pend_r <= pend_nxt;
      force_r <= force_nxt;
      hold_r <= hold_nxt;
      active_r <= active_nxt;
    end
  end

  assign hold_out = hold_r;
  assign active_out = active_r;
  assign pending_out = pend_r;

  // Unsafe clocks keep the old source in place
  defer_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    pend_r && !force_r && !safe_in && !req_in |=> $stable(active_r))
    else $error("source changed before clocks were safe");

  // Forced request lands on the next edge with nothing left pending
  force_now_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    clk_en_in && req_in && force_in
      |=> active_r == $past(value_in) && !pend_r)
    else $error("forced switch not immediate");
endmodule : arcdr_apply_gate
`default_nettype wire

/* bench/arcdr_partner.sv */
// Purpose: Behavioural audio sources on the far side of the router.
// Assumes: Link clocks run only while run_in is high, else rest low.
// Notes:   Data lines carry a changing pattern at all times.
`timescale 1ns/1ns
`default_nettype none
module arcdr_partner (
  input wire logic run_in,
  output logic [4:0] mclk_out,
  output logic [4:0] bclk_out,
  output logic [4:0] fclk_out,
  output logic [4:0] data_out,
  output logic [1:0] gpio_out,
  output logic [5:0] conv_out,
  output logic rec_data_out
);
  logic [15:0] k;
  logic [15:0] lf;

  // Phase counter and data pattern, unrelated to the system clock
  initial begin
    k = 16'h0000;
    lf = 16'hACE1;
    #7;
    forever begin
      #100;
      if (run_in) begin
        k = k + 16'h0001;
      end
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    end
  end

  // Clocks stand low between frames; all are counter bits, so several sources share a rate
  assign mclk_out = run_in ? k[4:0] : 5'h00;
  assign bclk_out = run_in ? k[5:1] : 5'h00;
  assign fclk_out = run_in ? k[8:4] : 5'h00;
  assign conv_out = run_in ? {k[1], k[9], k[3], k[7], k[2], k[6]} : 6'h00;
  // Data lines keep moving so a stale route cannot pass
  assign data_out = lf[4:0];
  assign gpio_out = lf[6:5];
  assign rec_data_out = lf[7];
endmodule : arcdr_partner
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the audio port router.
// Assumes: Forced applies land at the edge that closes the write.
// Notes:   Monitor compares read data and pin snapshots in order.
`timescale 1ns/1ns
`default_nettype none
`include "arcdr_regs.svh"
`define CHK(nm, e, g) \
  begin \
    n_tests++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  logic clk, rst, hsel, hwrite, rd_dp, obs, run, hrdy, hresp, rdat, ramp;
  logic [1:0] htrans, gp, mo, moe, bo, fo, poe, dout, doe;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [4:0] pm, pb, pf, pd;
  logic [5:0] cv;
  logic [2:0] dx;
  logic [14:0] seen;
  logic [20:0] act;
  logic [32:0] ent;
  logic [32:0] q[$];
  int mismatches, n_tests, cyc;

  arcdr_partner u_arcdr_partner (.run_in(run), .mclk_out(pm), .bclk_out(pb),
    .fclk_out(pf), .data_out(pd), .gpio_out(gp), .conv_out(cv),
    .rec_data_out(rdat));
  arcdr_top u_arcdr_top (.clock_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
    .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .master_clk_in(pm), .bit_clk_in(pb), .frame_clk_in(pf), .data_in(pd),
    .gpio_data_in(gp), .playback_one_bit_clock_in(cv[1]),
    .playback_one_frame_clock_in(cv[0]), .playback_two_bit_clock_in(cv[3]),
    .playback_two_frame_clock_in(cv[2]), .record_bit_clock_in(cv[5]),
    .record_frame_clock_in(cv[4]), .record_data_in(rdat),
    .master_clk_out(mo), .master_clk_oe_out(moe), .bit_clk_out(bo),
    .frame_clk_out(fo), .pair_oe_out(poe), .data_out(dout),
    .data_oe_out(doe), .ramp_clock_out(ramp));

  // Pin snapshot; undriven clock pins are masked, data must read zero
  assign dx = {rdat, gp};
  assign seen = {ramp, doe, dout, poe, bo & poe, fo & poe, moe, mo & moe};

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [31:0] adr(input int s);
    logic [7:0] ix;
    ix = (s == 2) ? `ARCDR_RAMP_IDX : (s == 0) ? `ARCDR_PORT1_IDX :
      `ARCDR_PORT2_IDX;
    return {22'h0, ix, 2'b00};
  endfunction : adr

  // Expected pins from the active codes and the live source lines
  function automatic logic [14:0] exp_pins(input logic [20:0] c);
    int m, k, d, r;
    logic [14:0] v;
    v = '0;
    for (int p = 0; p < 2; p++) begin
      m = int'(c[p*9 +: 3]);
      k = int'(c[p*9+3 +: 3]);
      d = int'(c[p*9+6 +: 3]);
      if (m != p && m < 5) begin
        v[2+p] = 1'b1;
        v[p] = pm[m];
      end
      if (k != p) begin
        v[8+p] = 1'b1;
        {v[6+p], v[4+p]} = (k < 5) ? {pb[k], pf[k]} : cv[(k-5)*2 +: 2];
      end
      if (d != p) begin
        v[12+p] = 1'b1;
        v[10+p] = (d < 5) ? pd[d] : dx[d-5];
      end
    end
    r = int'(c[20:18]);
    v[14] = (r < 5) ? pf[r] : cv[(r-5)*2];
    return v;
  endfunction : exp_pins

  task automatic wait_rdy;
    @(negedge clk);
    while (hrdy !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask : wait_rdy

  // One AHB-Lite single word transfer
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= !wr;
    wait_rdy();
    rd_dp <= 1'b0;
  endtask : bus

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back({1'b0, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic chk;
    q.push_back({1'b1, 11'h000, act});
    obs <= 1'b1;
    @(posedge clk);
    obs <= 1'b0;
  endtask : chk

  task automatic set_act(input int s, input logic [31:0] v);
    if (s == 2) begin
      act[20:18] = v[3:1];
    end else begin
      act[s*9 +: 9] = v[9:1];
    end
  endtask : set_act

  // Register write; a deferred apply is held off until the links rest
  task automatic put(input int s, input logic [31:0] v);
    bus(1'b1, adr(s), v);
    if (v[10] === 1'b1) begin
      if (v[0] === 1'b0) begin
        chk();
        run <= 1'b0;
        repeat (8) @(posedge clk);
        run <= 1'b1;
      end
      set_act(s, v);
    end
  endtask : put

  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // System clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compares each appearing result with the oldest note
  always @(negedge clk) begin
    if (rd_dp && hrdy === 1'b1 && q.size() > 0) begin
      ent = q.pop_front();
      `CHK("read", {1'b0, ent[31:0]}, {hresp, hrdata})
    end
    if (obs && q.size() > 0) begin
      ent = q.pop_front();
      `CHK("pins", exp_pins(ent[20:0]), seen)
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = '0;
    hwrite = 1'b0;
    hwdata = '0;
    rd_dp = 1'b0;
    obs = 1'b0;
    run = 1'b1;
    rnd = 32'h43BE;
    act = {3'h1, 9'h049, 9'h000};
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk();
    rd(adr(2), {16'h0, `ARCDR_RAMP_RST});
    rd(adr(0), {16'h0, `ARCDR_PORT1_RST});
    rd(adr(1), {16'h0, `ARCDR_PORT2_RST});
    rd({22'h0, `ARCDR_STATUS_IDX, 2'b00}, 32'h0000_0010);
    // Unmapped places ignore writes and read zero
    bus(1'b1, 32'h0000_0494, 32'h0000_07FF);
    bus(1'b1, 32'h0000_00A0, 32'h0000_07FF);
    rd(32'h0000_0494, 32'h0000_0000);
    rd(32'h0000_00A0, 32'h0000_0000);
    rd(adr(0), 32'h0000_0000);
    // Writes without apply only store
    for (int s = 0; s < 3; s++) begin
      put(s, 32'h0000_03FF);
      chk();
      rd(adr(s), (s == 2) ? 32'h0000_000F : 32'h0000_03FF);
    end
    // Forced applies walk every master and ramp code, port one data and port two pair codes
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      put(0, {rnd[31:11], 1'b1, 3'(i), rnd[4:2], 3'(i), 1'b1});
      put(1, {rnd[31:11], 1'b1, rnd[7:5], 3'(i), 3'(i), 1'b1});
      put(2, {rnd[31:11], 7'h40, 3'(i), 1'b1});
      chk();
      rd(adr(0), {22'h0, 3'(i), rnd[4:2], 3'(i), 1'b1});
      rd(adr(2), {28'h0, 3'(i), 1'b1});
    end
    // Deferred applies wait for resting clocks
    put(1, 32'h0000_0746);
    chk();
    put(2, 32'h0000_0404);
    chk();
    rd({22'h0, `ARCDR_STATUS_IDX, 2'b00}, {25'h0, act[20:18], 4'h0});
    finish_test();
  end
endmodule : tb
`default_nettype wire
